/* usb_endpoint_decode_fifos.sv */
// Endpoint address decode, control FIFO and six unidirectional endpoint FIFOs
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module usb_endpoint_decode_fifos
  import usb_ep_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Tokens and received bytes from the serial engine
  input wire token_t token_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_end_in,
  input wire logic rx_err_in,
  // Transmit bytes to the serial engine
  input wire logic tx_rd_in,
  input wire logic tx_end_in,
  input wire logic tx_ack_in,
  output logic [7:0] tx_data_out,
  output logic tx_empty_out,
  output logic tx_last_out,
  output logic ep_sel_valid_out,
  output logic [2:0] ep_sel_out
);

  state_t q;
  state_t d;

  // ---------------------------------------------------------------------------
  // Per-FIFO levels
  // ---------------------------------------------------------------------------
  logic [2:0] tx_empty;
  logic [2:0] tx_full;
  logic [2:0] rx_empty;
  logic [2:0] rx_full;
  logic [2:0] sel_tx;
  logic [2:0] sel_rx;
  logic [2:0][6:0] tx_fill;
  logic [2:0][6:0] tx_free;
  logic [2:0][6:0] rx_used;
  logic [2:0][6:0] rx_space;
  logic [6:0] ok_in;
  logic [6:0] ok_out;

  // Control endpoint takes part only in the direction its state waits for
  assign ok_in[0] = (q.cst == C_TX_WAIT); // RULE5
  assign ok_out[0] = (q.cst == C_RXWAIT); // RULE5

  for (genvar k = 0; k < NUM_UNI; k++) begin : g_fifo
    // Seven-bit pointers over a 64-entry store: the top bit tells full from empty
    assign tx_fill[k] = q.tx[k].wp - q.tx[k].rp; // RULE22
    assign tx_free[k] = UNI_DEPTH - tx_fill[k]; // RULE15
    assign tx_empty[k] = (tx_fill[k] == 7'h00);
    assign tx_full[k] = (tx_fill[k] == UNI_DEPTH);
    assign rx_used[k] = q.rx[k].wp - q.rx[k].rp; // RULE22
    assign rx_space[k] = UNI_DEPTH - rx_used[k]; // RULE18
    assign rx_empty[k] = (rx_used[k] == 7'h00);
    assign rx_full[k] = (rx_used[k] == UNI_DEPTH);
    // Isochronous endpoints step aside when empty or full, allowing ping-pong pairs
    assign ok_in[2*k+1] = !q.epc[2*k+1].iso || !tx_empty[k]; // RULE4
    assign ok_out[2*k+1] = 1'b0;
    assign ok_in[2*k+2] = 1'b0;
    assign ok_out[2*k+2] = !q.epc[2*k+2].iso || !rx_full[k]; // RULE4
    assign sel_tx[k] = q.sel_v && (q.sel == 3'(2*k+1));
    assign sel_rx[k] = q.sel_v && (q.sel == 3'(2*k+2));

    tx_level_bound_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE11
      tx_fill[k] <= UNI_DEPTH && rx_used[k] <= UNI_DEPTH)
      else $error("fifo level beyond depth");

    tx_full_ignore_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE13
      reg_req_in.wr && reg_req_in.addr[5:4] == GRP_TX && reg_req_in.addr[3:2] == 2'(k)
      && reg_req_in.addr[1:0] == OFS_DATA && tx_full[k] |=> $stable(q.tx[k].wp))
      else $error("write into full transmit fifo moved pointer");

    tx_underrun_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE12
      tx_rd_in && sel_tx[k] && tx_empty[k] && !q.tx[k].last
      |=> q.tx[k].flag && $stable(q.tx[k].rp))
      else $error("transmit underrun not flagged");

    rx_repeat_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE16
      reg_req_in.rd && reg_req_in.addr[5:4] == GRP_RX && reg_req_in.addr[3:2] == 2'(k)
      && reg_req_in.addr[1:0] == OFS_DATA && rx_empty[k] |=> $stable(q.rx[k].rp))
      else $error("empty receive read moved pointer");

    rx_overrun_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE17
      rx_valid_in && sel_rx[k] && rx_full[k] |=> q.rx[k].flag && $stable(q.rx[k].wp))
      else $error("receive overrun not flagged");

    tx_warn_set_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE14
      tx_fill[k] <= q.tx[k].thr |=> q.warn[k])
      else $error("transmit warning missing");

    rx_warn_set_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE19
      rx_space[k] <= q.rx[k].thr |=> q.warn[k+3])
      else $error("receive warning missing");
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Firmware effects are applied first so that hardware events in the same
  // cycle override any clear of a flag.
  always_comb begin
    logic [1:0] grp;
    logic [1:0] ofs;
    logic [1:0] fk;
    logic is_in;
    logic addr_ok;
    logic pick_v;
    logic [2:0] pick;
    grp = reg_req_in.addr[5:4];
    ofs = reg_req_in.addr[1:0];
    fk = reg_req_in.addr[3:2];
    is_in = (token_in.pid == PID_IN);
    addr_ok = 1'b0;
    pick_v = 1'b0;
    pick = 3'h0;
    d = q;
    d.rdata = 8'h00;

    if (reg_req_in.wr) begin
      if (reg_req_in.addr == ADDR_FUNC_ADDR) begin
        d.func_addr = reg_req_in.wdata[6:0];
      end else if (reg_req_in.addr >= ADDR_EPC_FIRST && reg_req_in.addr <= ADDR_EPC_LAST) begin
        d.epc[3'(reg_req_in.addr - ADDR_EPC_FIRST)] = reg_req_in.wdata[6:0];
      end else if (reg_req_in.addr == ADDR_CTRL_CMD) begin
        if (reg_req_in.wdata[CC_FLUSH_BIT]) begin
          d.cwp = 4'h0; // RULE9
          d.crp = 4'h0; // RULE9
          d.cst = C_IDLE; // RULE9
        end else if (q.cst == C_IDLE && reg_req_in.wdata[CC_TXEN_BIT]) begin
          // No bytes needed: an empty FIFO goes out as a zero-length packet
          d.cst = C_TX_WAIT; // RULE10
        end else if (q.cst == C_IDLE && reg_req_in.wdata[CC_RXEN_BIT]) begin
          d.cst = C_RXWAIT;
        end
      end else if (reg_req_in.addr == ADDR_CTRL_DATA) begin
        if (q.cst == C_IDLE && q.cwp < CTRL_FULL) begin
          d.cmem[q.cwp[2:0]] = reg_req_in.wdata; // RULE2
          d.cwp = q.cwp + 4'h1;
        end
      end else if (grp == GRP_TX && fk <= UNI_LAST) begin
        if (ofs == OFS_DATA && !tx_full[fk]) begin
          d.tx[fk].mem[q.tx[fk].wp[5:0]] = reg_req_in.wdata; // RULE13
          d.tx[fk].wp = q.tx[fk].wp + 7'h01; // RULE13
        end else if (ofs == OFS_CMD) begin
          d.tx[fk].last = reg_req_in.wdata[UC_LAST_BIT];
          if (reg_req_in.wdata[UC_FLUSH_BIT]) begin
            d.tx[fk].wp = 7'h00;
            d.tx[fk].rp = 7'h00;
            d.tx[fk].flag = 1'b0;
          end
        end else if (ofs == OFS_THR) begin
          d.tx[fk].thr = reg_req_in.wdata[6:0];
        end
      end else if (grp == GRP_RX && fk <= UNI_LAST) begin
        if (ofs == OFS_CMD && reg_req_in.wdata[UC_FLUSH_BIT]) begin
          d.rx[fk].wp = 7'h00;
          d.rx[fk].rp = 7'h00;
          d.rx[fk].flag = 1'b0;
        end else if (ofs == OFS_THR) begin
          d.rx[fk].thr = reg_req_in.wdata[6:0];
        end
      end
    end

    if (reg_req_in.rd) begin
      if (reg_req_in.addr == ADDR_FUNC_ADDR) begin
        d.rdata = {1'b0, q.func_addr};
      end else if (reg_req_in.addr >= ADDR_EPC_FIRST && reg_req_in.addr <= ADDR_EPC_LAST) begin
        d.rdata = {1'b0, q.epc[3'(reg_req_in.addr - ADDR_EPC_FIRST)]};
      end else if (reg_req_in.addr == ADDR_CTRL_CMD) begin
        d.rdata = {1'b0, q.crx_done, q.ctx_done, 2'h0, q.cst};
        d.ctx_done = 1'b0;
        d.crx_done = 1'b0;
      end else if (reg_req_in.addr == ADDR_CTRL_DATA) begin
        if (q.crp < q.cwp) begin
          d.rdata = q.cmem[q.crp[2:0]];
          d.crp = q.crp + 4'h1;
        end else begin
          d.rdata = q.cmem[q.crp[2:0] - 3'h1];
        end
      end else if (reg_req_in.addr == ADDR_WARN) begin
        d.rdata = {2'h0, q.warn};
        d.warn = 6'h00;
      end else if (grp == GRP_TX && fk <= UNI_LAST) begin
        if (ofs == OFS_CMD) begin
          d.rdata = {q.tx[fk].flag, 5'h00, q.tx[fk].last, 1'b0};
          d.tx[fk].flag = 1'b0;
        end else if (ofs == OFS_THR) begin
          d.rdata = {1'b0, q.tx[fk].thr};
        end else if (ofs == OFS_STAT) begin
          d.rdata = {1'b0, tx_free[fk]}; // RULE15
        end
      end else if (grp == GRP_RX && fk <= UNI_LAST) begin
        if (ofs == OFS_DATA) begin
          if (!rx_empty[fk]) begin
            d.rdata = q.rx[fk].mem[q.rx[fk].rp[5:0]];
            d.rx[fk].rp = q.rx[fk].rp + 7'h01; // RULE16
          end else begin
            // Reading past the end repeats the last byte and holds the pointer
            d.rdata = q.rx[fk].mem[q.rx[fk].rp[5:0] - 6'h01]; // RULE16
          end
        end else if (ofs == OFS_CMD) begin
          d.rdata = {q.rx[fk].flag, 7'h00};
          d.rx[fk].flag = 1'b0;
        end else if (ofs == OFS_THR) begin
          d.rdata = {1'b0, q.rx[fk].thr};
        end else begin
          d.rdata = {1'b0, rx_used[fk]}; // RULE20
        end
      end
    end

    // Token decode: scan from the top so the lowest matching index wins
    if (token_in.valid) begin
      for (int i = NUM_EP - 1; i >= 0; i--) begin
        addr_ok = (token_in.addr == q.func_addr) // RULE1
          || (i == 0 && q.epc[0].dflt_en && token_in.addr == 7'h00); // RULE6
        if (addr_ok && q.epc[i].en && q.epc[i].num == token_in.endp
            && (is_in ? ok_in[i] : ok_out[i])) begin // RULE1
          pick_v = 1'b1; // RULE4
          pick = 3'(i); // RULE4
        end
      end
      d.sel_v = pick_v;
      d.sel = pick;
    end

    if (rx_valid_in && q.sel_v) begin
      if (q.sel == 3'h0) begin
        if (q.cst == C_RXWAIT && q.cwp < CTRL_FULL) begin
          d.cmem[q.cwp[2:0]] = rx_data_in;
          d.cwp = q.cwp + 4'h1;
        end
      end
      for (int k = 0; k < NUM_UNI; k++) begin
        if (sel_rx[k]) begin
          if (rx_full[k]) begin
            d.rx[k].flag = 1'b1; // RULE17
          end else begin
            d.rx[k].mem[q.rx[k].wp[5:0]] = rx_data_in;
            d.rx[k].wp = q.rx[k].wp + 7'h01; // RULE17
          end
        end
      end
    end

    if (rx_end_in) begin
      if (q.sel_v && q.sel == 3'h0 && q.cst == C_RXWAIT) begin
        if (rx_err_in) begin
          d.cwp = 4'h0; // RULE8
        end else begin
          d.crx_done = 1'b1; // RULE8
          d.cst = C_IDLE;
        end
      end
      d.sel_v = 1'b0;
    end

    if (tx_rd_in && q.sel_v) begin
      if (q.sel == 3'h0 && q.crp < q.cwp) begin
        d.txdata = q.cmem[q.crp[2:0]];
        d.crp = q.crp + 4'h1;
      end
      for (int k = 0; k < NUM_UNI; k++) begin
        if (sel_tx[k]) begin
          if (!tx_empty[k]) begin
            d.txdata = q.tx[k].mem[q.tx[k].rp[5:0]];
            d.tx[k].rp = q.tx[k].rp + 7'h01; // RULE11
          end else if (!q.tx[k].last) begin
            d.tx[k].flag = 1'b1; // RULE12
          end
        end
      end
    end

    if (tx_end_in) begin
      if (q.sel_v && q.sel == 3'h0 && q.cst == C_TX_WAIT) begin
        if (tx_ack_in) begin
          d.cwp = 4'h0;
          d.crp = 4'h0;
          d.ctx_done = 1'b1;
          d.cst = C_IDLE;
        end else begin
          // Data kept; rewind so the next IN resends the whole packet
          d.crp = 4'h0; // RULE7
        end
      end
      for (int k = 0; k < NUM_UNI; k++) begin
        if (sel_tx[k] && tx_ack_in) begin
          d.tx[k].last = 1'b0;
        end
      end
      d.sel_v = 1'b0;
    end

    // Warnings are levels sampled into sticky bits; a read clears only if the
    // condition has gone away.
    for (int k = 0; k < NUM_UNI; k++) begin
      if (tx_fill[k] <= q.tx[k].thr) begin
        d.warn[k] = 1'b1; // RULE14
      end
      if (rx_space[k] <= q.rx[k].thr) begin
        d.warn[k+3] = 1'b1; // RULE19
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.cst <= C_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    tx_empty_out = 1'b1;
    tx_last_out = 1'b1;
    if (q.sel_v && q.sel == 3'h0) begin
      tx_empty_out = (q.crp >= q.cwp);
    end
    for (int k = 0; k < NUM_UNI; k++) begin
      if (sel_tx[k]) begin
        tx_empty_out = tx_empty[k];
        tx_last_out = q.tx[k].last;
      end
    end
  end

  assign reg_rdata_out = q.rdata;
  assign tx_data_out = q.txdata;
  assign ep_sel_valid_out = q.sel_v;
  assign ep_sel_out = q.sel;

  // ---------------------------------------------------------------------------
  // Control endpoint and token address checks
  // ---------------------------------------------------------------------------
  ctrl_zero_len_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE10
    reg_req_in.wr && reg_req_in.addr == ADDR_CTRL_CMD && q.cst == C_IDLE
    && reg_req_in.wdata[CC_TXEN_BIT] && !reg_req_in.wdata[CC_FLUSH_BIT]
    |=> q.cst == C_TX_WAIT)
    else $error("transmit enable did not reach transmit wait");

  ctrl_retry_keep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE7
    tx_end_in && !tx_ack_in && q.sel_v && q.sel == 3'h0 && q.cst == C_TX_WAIT
    && !reg_req_in.wr |=> q.crp == 4'h0 && $stable(q.cwp) && q.cst == C_TX_WAIT)
    else $error("control packet not kept for retry");

  ctrl_err_drop_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE8
    rx_end_in && rx_err_in && q.sel_v && q.sel == 3'h0 && q.cst == C_RXWAIT
    && !reg_req_in.wr |=> q.cwp == 4'h0 && q.cst == C_RXWAIT && $stable(q.crx_done))
    else $error("erroneous control reception reported");

  addr_miss_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE1
    token_in.valid && token_in.addr != q.func_addr && token_in.addr != 7'h00
    |=> !q.sel_v)
    else $error("token for other address selected an endpoint");

  // Only checked outside a transfer: bytes moving in the same cycle would refill the FIFO
  ctrl_flush_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE9
    reg_req_in.wr && reg_req_in.addr == ADDR_CTRL_CMD && reg_req_in.wdata[CC_FLUSH_BIT]
    && !q.sel_v |=> q.cwp == 4'h0 && q.crp == 4'h0 && q.cst == C_IDLE)
    else $error("control fifo flush incomplete");

endmodule : usb_endpoint_decode_fifos

/* usb_endpoint_decode_fifos_tb.sv */
// Self-checking testbench for the endpoint decode and FIFO block
`timescale 1ns/1ps
module usb_endpoint_decode_fifos_tb;
  import usb_ep_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t reg_req_in = '0;
  token_t token_in;
  logic rx_valid_in, rx_end_in, rx_err_in, tx_rd_in, tx_end_in, tx_ack_in;
  logic [7:0] rx_data_in, tx_data_out, reg_rdata_out, v;
  logic tx_empty_out, tx_last_out, ep_sel_valid_out;
  logic [2:0] ep_sel_out;
  int err_total = 0;
  int samples_checked = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  usb_endpoint_decode_fifos u_usb_endpoint_decode_fifos (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .token_in(token_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_end_in(rx_end_in), .rx_err_in(rx_err_in), .tx_rd_in(tx_rd_in),
    .tx_end_in(tx_end_in), .tx_ack_in(tx_ack_in), .tx_data_out(tx_data_out),
    .tx_empty_out(tx_empty_out), .tx_last_out(tx_last_out),
    .ep_sel_valid_out(ep_sel_valid_out), .ep_sel_out(ep_sel_out));

  usb_host_model u_usb_host_model (.ref_clk_in(ref_clk_in), .token_out(token_in),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .rx_end_out(rx_end_in),
    .rx_err_out(rx_err_in), .tx_rd_out(tx_rd_in), .tx_end_out(tx_end_in),
    .tx_ack_out(tx_ack_in), .tx_data_in(tx_data_out));

  // ---------------------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    reg_req_in.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    reg_req_in.rd <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp);
  endtask : chk_rd

  // Expected selection: bit 3 valid, bits 2:0 endpoint index
  task automatic tok(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e,
                     input logic [3:0] exp);
    u_usb_host_model.token(p, a, e);
    #1;
    chk8({7'h00, ep_sel_valid_out}, {7'h00, exp[3]});
    if (exp[3]) begin
      chk8({5'h00, ep_sel_out}, {5'h00, exp[2:0]});
    end
  endtask : tok

  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    wr(6'h00, 8'h05);
    wr(6'h01, 8'h60);
    wr(6'h02, 8'h21);
    wr(6'h03, 8'h22);
    // Transmit FIFO a: fill past full, then drain into underrun
    wr(6'h12, 8'h02);
    for (int i = 0; i < 65; i++) wr(6'h10, 8'hA0 + i[7:0]);
    chk_rd(6'h13, 8'h00);
    rd(6'h30, v);
    chk_rd(6'h30, 8'h06);
    tok(PID_IN, 7'h05, 4'h1, 4'h9);
    for (int i = 0; i < 64; i++) begin
      u_usb_host_model.get(v);
      chk8(v, 8'hA0 + i[7:0]);
    end
    chk8({7'h00, tx_empty_out}, 8'h01);
    u_usb_host_model.get(v);
    chk8(v, 8'hDF);
    chk_rd(6'h11, 8'h80);
    chk_rd(6'h13, 8'h40);
    chk_rd(6'h30, 8'h07);
    wr(6'h10, 8'h5A);
    u_usb_host_model.get(v);
    chk8(v, 8'h5A);
    wr(6'h11, 8'h02);
    #1;
    chk8({7'h00, tx_last_out}, 8'h01);
    u_usb_host_model.get(v);
    chk_rd(6'h11, 8'h02);
    u_usb_host_model.done(1'b1);
    chk_rd(6'h11, 8'h00);
    tok(PID_IN, 7'h06, 4'h1, 4'h0);
    tok(PID_IN, 7'h05, 4'h7, 4'h0);
    // Shared endpoint numbers
    wr(6'h04, 8'h21);
    wr(6'h03, 8'h21);
    tok(PID_IN, 7'h05, 4'h1, 4'h9);
    wr(6'h02, 8'h31);
    tok(PID_IN, 7'h05, 4'h1, 4'hB);
    tok(PID_OUT, 7'h05, 4'h1, 4'hA);
    wr(6'h02, 8'h01);
    tok(PID_IN, 7'h05, 4'h1, 4'hB);
    wr(6'h03, 8'h22);
    // Receive FIFO a: fill, overrun, drain past empty
    tok(PID_OUT, 7'h05, 4'h2, 4'hA);
    for (int i = 0; i < 64; i++) u_usb_host_model.put(8'h30 + i[7:0]);
    chk_rd(6'h23, 8'h40);
    rd(6'h30, v);
    chk_rd(6'h30, 8'h0F);
    u_usb_host_model.put(8'hEE);
    chk_rd(6'h21, 8'h80);
    u_usb_host_model.fin(1'b0);
    for (int i = 0; i < 64; i++) chk_rd(6'h20, 8'h30 + i[7:0]);
    chk_rd(6'h20, 8'h6F);
    chk_rd(6'h23, 8'h00);
    // Control endpoint: nack retry, zero length, errored and clean receive, flush
    wr(6'h09, 8'h11);
    wr(6'h09, 8'h22);
    wr(6'h09, 8'h33);
    wr(6'h08, 8'h01);
    chk_rd(6'h08, 8'h02);
    for (int k = 0; k < 2; k++) begin
      tok(PID_IN, k[0] ? 7'h05 : 7'h00, 4'h0, 4'h8);
      for (int i = 0; i < 3; i++) begin
        u_usb_host_model.get(v);
        chk8(v, 8'h11 * (i[7:0] + 8'h01));
      end
      u_usb_host_model.done(k[0]);
    end
    chk_rd(6'h08, 8'h21);
    wr(6'h08, 8'h01);
    chk_rd(6'h08, 8'h02);
    tok(PID_IN, 7'h05, 4'h0, 4'h8);
    chk8({7'h00, tx_empty_out}, 8'h01);
    u_usb_host_model.done(1'b1);
    chk_rd(6'h08, 8'h21);
    wr(6'h08, 8'h02);
    chk_rd(6'h08, 8'h04);
    tok(PID_SETUP, 7'h05, 4'h0, 4'h8);
    u_usb_host_model.put(8'h5A);
    u_usb_host_model.put(8'hC3);
    u_usb_host_model.fin(1'b1);
    chk_rd(6'h08, 8'h04);
    tok(PID_OUT, 7'h05, 4'h0, 4'h8);
    u_usb_host_model.put(8'h77);
    u_usb_host_model.fin(1'b0);
    chk_rd(6'h08, 8'h41);
    chk_rd(6'h09, 8'h77);
    wr(6'h08, 8'h04);
    wr(6'h09, 8'h99);
    wr(6'h08, 8'h01);
    tok(PID_IN, 7'h05, 4'h0, 4'h8);
    u_usb_host_model.get(v);
    chk8(v, 8'h99);
    u_usb_host_model.done(1'b1);
    end_of_test();
  end
endmodule : usb_endpoint_decode_fifos_tb

/* usb_ep_pkg.sv */
// Constants and types for the endpoint decode and FIFO block
// -----------------------------------------------------------------------------
// Function
// RULE1 - Token address matched against function address, then endpoint against all endpoints
// RULE2 - Seven FIFOs: 8-byte control, three 64-byte transmit, three 64-byte receive
// RULE3 - Firmware never enables control transmit and receive together
// RULE4 - Same-number same-direction endpoints: lowest index wins until disabled or full/empty; code steps aside on full/empty only for isochronous endpoints
// RULE5 - Opposite-direction endpoints sharing a number work independently
// RULE6 - Control FIFO answers default address when enabled; no isochronous on control
// RULE7 - Control FIFO keeps its packet on error and resends on the next IN
// RULE8 - Control OUT data reported only without error; erroneous data discarded
// RULE9 - Firmware can flush the control FIFO
// RULE10 - Transmit enable moves control idle straight to transmit wait
// RULE11 - Transmit read pointer advances per read, wraps, never passes write pointer
// RULE12 - Transmit underrun when empty, more bytes wanted and last bit clear
// RULE13 - Transmit write pointer advances per firmware write; write to full FIFO ignored
// RULE14 - Transmit warning flag set when fill level at or below threshold
// RULE15 - Transmit status shows free byte count
// RULE16 - Receive read pointer advances per read, wraps; empty read repeats last byte
// RULE17 - Receive write pointer advances per write; overrun flagged when write into full
// RULE18 - Receive remaining space tracked per FIFO
// RULE19 - Receive warning flag set when space at or below threshold
// RULE20 - Receive status shows readable byte count
// RULE21 - Firmware refills and drains FIFOs during packets longer than the FIFO
// RULE22 - Pointers carry an extra wrap bit so full and empty differ
// -----------------------------------------------------------------------------
package usb_ep_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_EP = 7;
  localparam int NUM_UNI = 3;
  localparam logic [3:0] CTRL_FULL = 4'h8;
  localparam logic [6:0] UNI_DEPTH = 7'h40;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [5:0] ADDR_FUNC_ADDR = 6'h00;
  localparam logic [5:0] ADDR_EPC_FIRST = 6'h01;
  localparam logic [5:0] ADDR_EPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_CTRL_CMD = 6'h08;
  localparam logic [5:0] ADDR_CTRL_DATA = 6'h09;
  localparam logic [5:0] ADDR_WARN = 6'h30;
  localparam logic [1:0] GRP_MISC = 2'h0;
  localparam logic [1:0] GRP_TX = 2'h1;
  localparam logic [1:0] GRP_RX = 2'h2;
  localparam logic [1:0] UNI_LAST = 2'h2;
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_CMD = 2'h1;
  localparam logic [1:0] OFS_THR = 2'h2;
  localparam logic [1:0] OFS_STAT = 2'h3;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CC_TXEN_BIT = 0;
  localparam int CC_RXEN_BIT = 1;
  localparam int CC_FLUSH_BIT = 2;
  localparam int UC_LAST_BIT = 1;
  localparam int UC_FLUSH_BIT = 2;

  // ---------------------------------------------------------------------------
  // Token kinds
  // ---------------------------------------------------------------------------
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_SETUP = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [1:0] pid;
    logic [6:0] addr;
    logic [3:0] endp;
  } token_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic dflt_en;
    logic en;
    logic iso;
    logic [3:0] num;
  } epc_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_TX_WAIT = 3'b010,
    C_RXWAIT = 3'b100
  } ctrl_state_t;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [6:0] wp;
    logic [6:0] rp;
    logic last;
    logic flag;
    logic [6:0] thr;
  } ufifo_t;

  typedef struct packed {
    ctrl_state_t cst;
    logic [6:0] func_addr;
    epc_t [6:0] epc;
    logic [7:0][7:0] cmem;
    logic [3:0] cwp;
    logic [3:0] crp;
    logic ctx_done;
    logic crx_done;
    ufifo_t [2:0] tx;
    ufifo_t [2:0] rx;
    logic [5:0] warn;
    logic sel_v;
    logic [2:0] sel;
    logic [7:0] rdata;
    logic [7:0] txdata;
  } state_t;

endpackage : usb_ep_pkg

/* usb_host_model.sv */
// Serial engine stand-in: sends tokens and payload bytes, pulls transmit bytes
`timescale 1ns/1ps
module usb_host_model
  import usb_ep_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Toward the block
  output token_t token_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_end_out,
  output logic rx_err_out,
  output logic tx_rd_out,
  output logic tx_end_out,
  output logic tx_ack_out,
  // Byte handed back by the block
  input wire logic [7:0] tx_data_in
);
  initial begin
    token_out = '0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_end_out = 1'b0;
    rx_err_out = 1'b0;
    tx_rd_out = 1'b0;
    tx_end_out = 1'b0;
    tx_ack_out = 1'b0;
  end

  // Released fields are inverted so the block never profits from stale values
  task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e);
    @(posedge ref_clk_in);
    token_out <= {1'b1, p, a, e};
    @(posedge ref_clk_in);
    token_out <= ~{1'b1, p, a, e};
  endtask : token

  task automatic put(input logic [7:0] d);
    @(posedge ref_clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= d;
    @(posedge ref_clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~d;
  endtask : put

  task automatic fin(input logic err);
    @(posedge ref_clk_in);
    rx_end_out <= 1'b1;
    rx_err_out <= err;
    @(posedge ref_clk_in);
    rx_end_out <= 1'b0;
    rx_err_out <= ~err;
  endtask : fin

  task automatic get(output logic [7:0] d);
    @(posedge ref_clk_in);
    tx_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    tx_rd_out <= 1'b0;
    #1;
    d = tx_data_in;
  endtask : get

  task automatic done(input logic ack);
    @(posedge ref_clk_in);
    tx_end_out <= 1'b1;
    tx_ack_out <= ack;
    @(posedge ref_clk_in);
    tx_end_out <= 1'b0;
    tx_ack_out <= ~ack;
  endtask : done
endmodule : usb_host_model
